// ==== logic/rsrc_pkg.sv ====
`default_nettype none

package rsrc_pkg;

  // ----------------------------------------------------------------------
  // Latency counts
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W          = 10;
  localparam int unsigned SYS_OSC_CYCLES = 514;
  localparam int unsigned SHT_OSC_CYCLES = 66;
  localparam int unsigned SMR_OSC_CYCLES = 514;
  localparam int unsigned CLK_CYCLES     = 16;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADR_W        = 8;
  localparam logic [7:0]  ADDR_OPTION  = 8'h00;
  localparam logic [7:0]  ADDR_DEBUGGER = 8'h04;
  localparam logic [7:0]  ADDR_WAKE_EN = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
  localparam logic [7:0]  ADDR_CAUSE   = 8'h10;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned OPT_WDRES_BIT = 0;
  localparam int unsigned DEBUGGER_RST_BIT = 1;
  localparam int unsigned CAUSE_POR     = 0;
  localparam int unsigned CAUSE_BROWN   = 1;
  localparam int unsigned CAUSE_PIN     = 2;
  localparam int unsigned CAUSE_WDOG    = 3;
  localparam int unsigned CAUSE_DEBUGGER = 4;
  localparam int unsigned CAUSE_SMR     = 5;
  localparam int unsigned CAUSE_W       = 6;
  localparam int unsigned STAT_TYPE_LSB = 0;
  localparam int unsigned STAT_CPU_BIT  = 2;
  localparam int unsigned STAT_STOP_BIT = 3;
  localparam logic        OPT_RESET     = 1'h1;
  localparam int unsigned GPIO_N        = 8;

  typedef enum logic [1:0] {
    RSRC_NONE,
    RSRC_SYSTEM,
    RSRC_SHORT,
    RSRC_SMR
  } rsrc_type_e;

endpackage

`default_nettype wire

// ==== logic/rsrc_latency.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsrc_latency #(
  parameter int unsigned CNT_W      = rsrc_pkg::CNT_W,
  parameter int unsigned CLK_CYCLES = rsrc_pkg::CLK_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] osc_cycles_i,
  input  wire logic             osc_tick_i,
  output logic                  busy_o,
  output logic                  clk_phase_o,
  output logic                  done_o
);

  typedef enum logic [1:0] {LAT_IDLE, LAT_OSC, LAT_CLK} rsrc_lat_e;

  typedef struct packed {
    rsrc_lat_e        st;
    logic [CNT_W-1:0] cnt;
  } rsrc_lat_s;

  rsrc_lat_s cur;
  rsrc_lat_s next_cur;

  // ----------------------------------------------------------------------
  // Two-phase count
  // ----------------------------------------------------------------------
  // The slow oscillator portion runs first so that the clock has settled
  // before the short system-clock portion is counted.
  always_comb begin
    next_cur = cur;
    unique case (cur.st)
      LAT_IDLE: begin
      end
      LAT_OSC: begin
        if (osc_tick_i) begin
          if (cur.cnt <= CNT_W'(1)) begin
            next_cur.st  = LAT_CLK;
            next_cur.cnt = CNT_W'(CLK_CYCLES - 1);
          end else begin
            next_cur.cnt = cur.cnt - CNT_W'(1);
          end
        end
      end
      LAT_CLK: begin
        if (cur.cnt == '0) begin
          next_cur.st = LAT_IDLE;
        end else begin
          next_cur.cnt = cur.cnt - CNT_W'(1);
        end
      end
    endcase
    if (start_i) begin
      next_cur.st  = LAT_OSC;
      next_cur.cnt = osc_cycles_i;
    end
    if (rst_i) begin
      next_cur.st  = LAT_IDLE;
      next_cur.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  assign busy_o      = (cur.st != LAT_IDLE);
  assign clk_phase_o = (cur.st == LAT_CLK);
  assign done_o      = (cur.st == LAT_CLK) && (cur.cnt == '0);

endmodule

`default_nettype wire

// ==== logic/rsrc_wake_detect.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsrc_wake_detect #(
  parameter int unsigned N = rsrc_pkg::GPIO_N
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] gpio_i,
  input  wire logic [N-1:0] en_i,
  input  wire logic         stop_i,
  output logic              wake_o
);

  typedef struct packed {
    logic [N-1:0] prev;
    logic         armed;
    logic         wake;
  } rsrc_wake_s;

  rsrc_wake_s cur;
  rsrc_wake_s next_cur;

  // ----------------------------------------------------------------------
  // Edge detect
  // ----------------------------------------------------------------------
  // The armed bit hides the false edge that the cleared history would
  // otherwise show in the first cycle after reset.
  always_comb begin
    next_cur       = cur;
    next_cur.prev  = gpio_i;
    next_cur.armed = 1'h1;
    next_cur.wake  = cur.armed && stop_i && (|((gpio_i ^ cur.prev) & en_i));
    if (rst_i) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  assign wake_o = cur.wake;

endmodule

`default_nettype wire

// ==== logic/rsrc_top.sv ====
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module rsrc_top #(
  parameter int unsigned GPIO_N = rsrc_pkg::GPIO_N
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [rsrc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     por_i,
  input  wire logic                     supply_brownout_detect_i,
  input  wire logic                     ext_reset_n_i,
  input  wire logic                     watchdog_timeout_i,
  input  wire logic                     watchdog_osc_tick_i,
  input  wire logic                     stop_mode_i,
  input  wire logic                     debug_pin_i,
  input  wire logic [GPIO_N-1:0]        gpio_i,
  output logic                          cpu_reset_o,
  output logic                          ctrl_reg_reset_o,
  output logic                          watchdog_control_reg_reset_o,
  output logic                          watchdog_irq_o,
  output logic      [1:0]               reset_type_o
);

  typedef struct packed {
    logic                          ack;
    logic [31:0]                   rdat;
    logic                          opt_wdres;
    logic                          debugger_rst;
    logic [GPIO_N-1:0]             wake_en;
    logic [rsrc_pkg::CAUSE_W-1:0]  cause;
    logic                          cpu_rst;
    logic                          ctrl_rst;
    logic                          wctl_rst;
    logic                          irq;
    rsrc_pkg::rsrc_type_e          rtype;
  } rsrc_top_s;

  rsrc_top_s cur;
  rsrc_top_s next_cur;

  logic                       wr;
  logic                       rd;
  logic                       pin_req;
  logic                       sys_req;
  logic                       short_req;
  logic                       smr_req;
  logic                       start;
  logic                       gpio_wake;
  logic                       lat_done;
  logic                       lat_clk_phase;
  rsrc_pkg::rsrc_type_e       start_type;
  logic [rsrc_pkg::CNT_W-1:0] osc_load;

  function automatic logic [rsrc_pkg::CNT_W-1:0] osc_cycles(input rsrc_pkg::rsrc_type_e t);
    unique case (t)
      rsrc_pkg::RSRC_SHORT: osc_cycles = rsrc_pkg::CNT_W'(rsrc_pkg::SHT_OSC_CYCLES);
      rsrc_pkg::RSRC_SMR:   osc_cycles = rsrc_pkg::CNT_W'(rsrc_pkg::SMR_OSC_CYCLES);
      default:              osc_cycles = rsrc_pkg::CNT_W'(rsrc_pkg::SYS_OSC_CYCLES);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Reset sources and type choice
  // ----------------------------------------------------------------------
  // System-class sources restart the count every cycle they stay active, so the
  // latency runs from their release. Lower-class requests that arrive
  // while a reset is already running are dropped.
  assign pin_req   = por_i || supply_brownout_detect_i || !ext_reset_n_i;
  assign sys_req   = pin_req || cur.debugger_rst;
  assign short_req = watchdog_timeout_i && !stop_mode_i && cur.opt_wdres;
  assign smr_req   = stop_mode_i && (watchdog_timeout_i || gpio_wake || !debug_pin_i);
  assign start     = sys_req || (!cur.cpu_rst && (smr_req || short_req));

  always_comb begin
    if (sys_req) begin
      start_type = rsrc_pkg::RSRC_SYSTEM;
    end else if (smr_req) begin
      start_type = rsrc_pkg::RSRC_SMR;
    end else begin
      start_type = rsrc_pkg::RSRC_SHORT;
    end
  end

  assign osc_load = osc_cycles(start_type);

  rsrc_latency #(
    .CNT_W      (rsrc_pkg::CNT_W),
    .CLK_CYCLES (rsrc_pkg::CLK_CYCLES)
  ) u_latency (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .start_i      (start),
    .osc_cycles_i (osc_load),
    .osc_tick_i   (watchdog_osc_tick_i),
    .busy_o       (),
    .clk_phase_o  (lat_clk_phase),
    .done_o       (lat_done)
  );

  rsrc_wake_detect #(
    .N (GPIO_N)
  ) u_wake (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .gpio_i (gpio_i),
    .en_i   (cur.wake_en),
    .stop_i (stop_mode_i),
    .wake_o (gpio_wake)
  );

  // ----------------------------------------------------------------------
  // Bus slave and sequencing
  // ----------------------------------------------------------------------
  // Ack is registered, so every access costs one wait state; unmapped
  // addresses are acknowledged and read as zero.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !cur.ack && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !cur.ack;

  always_comb begin
    next_cur      = cur;
    next_cur.ack  = wb_cyc_i && wb_stb_i && !cur.ack;
    next_cur.rdat = '0;
    next_cur.irq  = watchdog_timeout_i && !stop_mode_i && !cur.opt_wdres;
    if (rd) begin
      unique case (wb_adr_i)
        rsrc_pkg::ADDR_OPTION:   next_cur.rdat[rsrc_pkg::OPT_WDRES_BIT] = cur.opt_wdres;
        rsrc_pkg::ADDR_DEBUGGER: next_cur.rdat[rsrc_pkg::DEBUGGER_RST_BIT] = cur.debugger_rst;
        rsrc_pkg::ADDR_WAKE_EN:  next_cur.rdat[GPIO_N-1:0] = cur.wake_en;
        rsrc_pkg::ADDR_CAUSE:    next_cur.rdat[rsrc_pkg::CAUSE_W-1:0] = cur.cause;
        rsrc_pkg::ADDR_STATUS: begin
          next_cur.rdat[rsrc_pkg::STAT_TYPE_LSB +: 2] = cur.rtype;
          next_cur.rdat[rsrc_pkg::STAT_CPU_BIT]       = cur.cpu_rst;
          next_cur.rdat[rsrc_pkg::STAT_STOP_BIT]      = stop_mode_i;
        end
        default: next_cur.rdat = '0;
      endcase
    end
    if (start) begin
      next_cur.debugger_rst = 1'h0;
    end
    if (wr) begin
      unique case (wb_adr_i)
        rsrc_pkg::ADDR_OPTION:   next_cur.opt_wdres = wb_dat_i[rsrc_pkg::OPT_WDRES_BIT];
        rsrc_pkg::ADDR_DEBUGGER: next_cur.debugger_rst = wb_dat_i[rsrc_pkg::DEBUGGER_RST_BIT];
        rsrc_pkg::ADDR_WAKE_EN:  next_cur.wake_en = wb_dat_i[GPIO_N-1:0];
        rsrc_pkg::ADDR_CAUSE:    next_cur.cause = cur.cause & ~wb_dat_i[rsrc_pkg::CAUSE_W-1:0];
        default: begin
        end
      endcase
    end
    // Cause flags are set after the clear so a new event is never lost.
    if (por_i) next_cur.cause[rsrc_pkg::CAUSE_POR] = 1'h1;
    if (supply_brownout_detect_i) next_cur.cause[rsrc_pkg::CAUSE_BROWN] = 1'h1;
    if (!ext_reset_n_i) next_cur.cause[rsrc_pkg::CAUSE_PIN] = 1'h1;
    if (cur.debugger_rst) next_cur.cause[rsrc_pkg::CAUSE_DEBUGGER] = 1'h1;
    if (start && start_type == rsrc_pkg::RSRC_SHORT) next_cur.cause[rsrc_pkg::CAUSE_WDOG] = 1'h1;
    if (start && start_type == rsrc_pkg::RSRC_SMR) next_cur.cause[rsrc_pkg::CAUSE_SMR] = 1'h1;
    if (start) begin
      next_cur.rtype    = start_type;
      next_cur.cpu_rst  = 1'h1;
      next_cur.wctl_rst = 1'h1;
      next_cur.ctrl_rst = (start_type != rsrc_pkg::RSRC_SMR);
    end else if (lat_done) begin
      next_cur.cpu_rst  = 1'h0;
      next_cur.wctl_rst = 1'h0;
      next_cur.ctrl_rst = 1'h0;
    end
    // Register-clearing resets also clear this block's own control state;
    // the option bit lives in nonvolatile storage and survives.
    if (cur.ctrl_rst) begin
      next_cur.wake_en = '0;
    end
    if (rst_i) begin
      next_cur           = '0;
      next_cur.opt_wdres = rsrc_pkg::OPT_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  assign wb_ack_o                     = cur.ack;
  assign wb_dat_o                     = cur.rdat;
  assign cpu_reset_o                  = cur.cpu_rst;
  assign ctrl_reg_reset_o             = cur.ctrl_rst;
  assign watchdog_control_reg_reset_o = cur.wctl_rst;
  assign watchdog_irq_o               = cur.irq;
  assign reset_type_o                 = cur.rtype;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_pin_sources: assert property (
    pin_req |=> cpu_reset_o && reset_type_o == rsrc_pkg::RSRC_SYSTEM)
    else $error("pin source did not start a system reset");

  chk_wdog_irq: assert property (
    watchdog_timeout_i && !stop_mode_i && !cur.opt_wdres && !sys_req && !cur.cpu_rst
      |=> watchdog_irq_o && !cpu_reset_o)
    else $error("watchdog time-out with select 0 must not reset");

  chk_debugger_rst: assert property (
    wr && wb_adr_i == rsrc_pkg::ADDR_DEBUGGER && wb_dat_i[rsrc_pkg::DEBUGGER_RST_BIT]
      |=> ##1 cpu_reset_o && reset_type_o == rsrc_pkg::RSRC_SYSTEM)
    else $error("debugger reset bit did not start a reset");

  chk_stop_debug: assert property (
    stop_mode_i && !debug_pin_i && !sys_req && !cur.cpu_rst
      |=> cpu_reset_o && reset_type_o == rsrc_pkg::RSRC_SMR)
    else $error("low debug pin in stop did not recover");

  chk_wake_mask: assert property (
    gpio_wake |-> |(($past(gpio_i, 1) ^ $past(gpio_i, 2)) & $past(cur.wake_en, 1)))
    else $error("wake from a pin that is not enabled");

  chk_type_mode: assert property (
    $rose(cpu_reset_o) && reset_type_o == rsrc_pkg::RSRC_SMR |-> $past(stop_mode_i))
    else $error("stop recovery outside stop mode");

  chk_sys_count: assert property (
    start && start_type == rsrc_pkg::RSRC_SYSTEM |-> osc_load == 10'h202)
    else $error("system reset loaded a wrong oscillator count");

  chk_short_count: assert property (
    start && start_type == rsrc_pkg::RSRC_SHORT |=> reset_type_o == rsrc_pkg::RSRC_SHORT
      && ctrl_reg_reset_o && $past(osc_load) == 10'h042)
    else $error("short reset has wrong count or effect");

  chk_smr_regs: assert property (
    cpu_reset_o && reset_type_o == rsrc_pkg::RSRC_SMR
      |-> !ctrl_reg_reset_o && watchdog_control_reg_reset_o)
    else $error("stop recovery touched control registers");

  chk_wdog_short: assert property (
    watchdog_timeout_i && !stop_mode_i && cur.opt_wdres && !sys_req && !cur.cpu_rst
      |=> cpu_reset_o && reset_type_o == rsrc_pkg::RSRC_SHORT && !watchdog_irq_o)
    else $error("watchdog time-out with select 1 did not short reset");

  chk_release_order: assert property (
    $fell(cpu_reset_o) |-> $past(lat_done) && $past(lat_clk_phase, 16))
    else $error("core released before both counts expired");

  cov_system: cover property ($fell(cpu_reset_o) && reset_type_o == rsrc_pkg::RSRC_SYSTEM);
  cov_short:  cover property ($fell(cpu_reset_o) && reset_type_o == rsrc_pkg::RSRC_SHORT);
  cov_smr:    cover property ($fell(cpu_reset_o) && reset_type_o == rsrc_pkg::RSRC_SMR);
  cov_irq:    cover property (watchdog_irq_o);

endmodule

`default_nettype wire

// ==== tb/rsrc_far_side.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsrc_far_side #(
  parameter int unsigned GPIO_N = 8
) (
  input  wire logic              clk_i,
  output logic                   por_o,
  output logic                   brown_o,
  output logic                   ext_reset_n_o,
  output logic                   timeout_o,
  output logic                   osc_tick_o,
  output logic                   stop_o,
  output logic                   debug_pin_o,
  output logic      [GPIO_N-1:0] gpio_o
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  // The reset pin and the debug pin idle high, as on pulled-up board nets.
  // The oscillator ticks every cycle to keep runs short; a real one is slower.
  initial begin
    por_o = 1'h0;
    brown_o = 1'h0;
    ext_reset_n_o = 1'h1;
    timeout_o = 1'h0;
    osc_tick_o = 1'h1;
    stop_o = 1'h0;
    debug_pin_o = 1'h1;
    gpio_o = '0;
  end

  // ----------------------------------------------------------------------
  // Source drivers
  // ----------------------------------------------------------------------
  task automatic hold_src(input int unsigned which, input int unsigned len);
    int unsigned i;
    @(posedge clk_i);
    case (which)
      0: por_o <= 1'h1;
      1: brown_o <= 1'h1;
      2: ext_reset_n_o <= 1'h0;
      default: timeout_o <= 1'h1;
    endcase
    for (i = 0; i < len; i++) @(posedge clk_i);
    por_o <= 1'h0;
    brown_o <= 1'h0;
    ext_reset_n_o <= 1'h1;
    timeout_o <= 1'h0;
  endtask

  task automatic set_lines(input logic stop, input logic dpin, input logic [GPIO_N-1:0] pins);
    @(posedge clk_i);
    stop_o <= stop;
    debug_pin_o <= dpin;
    gpio_o <= pins;
  endtask
endmodule

`default_nettype wire

// ==== tb/rsrc_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsrc_top_test;
  localparam int unsigned SYS_LEN = rsrc_pkg::SYS_OSC_CYCLES + rsrc_pkg::CLK_CYCLES;
  localparam int unsigned SHT_LEN = rsrc_pkg::SHT_OSC_CYCLES + rsrc_pkg::CLK_CYCLES;
  localparam int unsigned SMR_LEN = rsrc_pkg::SMR_OSC_CYCLES + rsrc_pkg::CLK_CYCLES;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, cpu_rst, ctrl_rst, wd_rst, wd_irq;
  logic        por, brown, ext_n, tmo, tick, stop, dpin;
  logic        ctrl_all, ctrl_any, wd_all, l_ctrl_all, l_ctrl_any, l_wd_all;
  logic [7:0]  wb_adr, gpio, m, g;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, d;
  logic [1:0]  rtype;
  int          n_errors, num_checks, seed, cycles, k, cidx;
  int unsigned hi_len, last_len, n_done, n_irq, base, len, i;

  always #5 clk_i = ~clk_i;

  rsrc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .por_i(por), .supply_brownout_detect_i(brown),
    .ext_reset_n_i(ext_n), .watchdog_timeout_i(tmo), .watchdog_osc_tick_i(tick),
    .stop_mode_i(stop), .debug_pin_i(dpin), .gpio_i(gpio), .cpu_reset_o(cpu_rst),
    .ctrl_reg_reset_o(ctrl_rst), .watchdog_control_reg_reset_o(wd_rst),
    .watchdog_irq_o(wd_irq), .reset_type_o(rtype));

  rsrc_far_side far (.clk_i(clk_i), .por_o(por), .brown_o(brown), .ext_reset_n_o(ext_n),
    .timeout_o(tmo), .osc_tick_o(tick), .stop_o(stop), .debug_pin_o(dpin), .gpio_o(gpio));

  // ----------------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------------
  // Each core reset span is measured whole, so a restart shows as extra length.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      close_out();
    end
    if (wd_irq === 1'h1) n_irq <= n_irq + 1;
    if (cpu_rst === 1'h1) begin
      hi_len <= hi_len + 1;
      ctrl_all <= (hi_len == 0 ? 1'h1 : ctrl_all) & ctrl_rst;
      ctrl_any <= (hi_len == 0 ? 1'h0 : ctrl_any) | ctrl_rst;
      wd_all <= (hi_len == 0 ? 1'h1 : wd_all) & wd_rst;
    end else if (hi_len != 0) begin
      last_len <= hi_len;
      l_ctrl_all <= ctrl_all;
      l_ctrl_any <= ctrl_any;
      l_wd_all <= wd_all;
      n_done <= n_done + 1;
      hi_len <= 0;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    int w;
    @(posedge clk_i);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= sel;
    w = 0;
    do begin
      @(posedge clk_i);
      w++;
    end while (wb_ack !== 1'h1 && w < 50);
    rd = wb_rdat;
    if (wb_ack !== 1'h1) begin
      $display("ERROR bus ack expected 1 seen %b", wb_ack);
      n_errors++;
    end
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] x;
    wb(1'h1, adr, dat, 4'hF, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'h0, adr, 32'h0, 4'hF, x);
    check(what, exp, x);
  endtask

  // A system-class source restarts the count on every sampled cycle it stays active.
  function automatic int unsigned exp_len(input logic [1:0] typ, input int unsigned hold);
    if (typ == 2'h2) exp_len = SHT_LEN + hold - 1;
    else if (typ == 2'h3) exp_len = SMR_LEN + hold - 1;
    else exp_len = SYS_LEN + hold - 1;
  endfunction

  task automatic wait_done(input int unsigned b);
    int w;
    w = 0;
    while (n_done == b && w < 3000) begin
      @(posedge clk_i);
      w++;
    end
    if (n_done == b) begin
      $display("ERROR reset end expected %0d seen %0d", b + 1, n_done);
      n_errors++;
    end
    @(posedge clk_i);
  endtask

  task automatic chk_reset(input string what, input int unsigned n, input logic [1:0] typ,
                           input logic ctrl);
    check({what, " length"}, n, last_len);
    check({what, " type"}, {30'h0, typ}, {30'h0, rtype});
    check({what, " ctrl all"}, {31'h0, ctrl}, {31'h0, l_ctrl_all});
    check({what, " ctrl any"}, {31'h0, ctrl}, {31'h0, l_ctrl_any});
    check({what, " wdog ctl"}, 32'h1, {31'h0, l_wd_all});
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    {n_errors, num_checks, cycles, hi_len, last_len, n_done, n_irq} = '0;
    {ctrl_all, ctrl_any, wd_all, l_ctrl_all, l_ctrl_any, l_wd_all} = '0;
    seed = 71306;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd_chk("option", rsrc_pkg::ADDR_OPTION, 32'h1);
    rd_chk("wake en", rsrc_pkg::ADDR_WAKE_EN, 32'h0);
    wr(rsrc_pkg::ADDR_STATUS, 32'hFF);
    rd_chk("status", rsrc_pkg::ADDR_STATUS, 32'h0);
    wr(8'h14, 32'hFF);
    rd_chk("unmapped", 8'h14, 32'h0);
    wb(1'h1, rsrc_pkg::ADDR_WAKE_EN, 32'hFF, 4'hE, d);
    rd_chk("masked write", rsrc_pkg::ADDR_WAKE_EN, 32'h0);
    $display("test bus done");
    for (k = 0; k < 4; k++) begin
      m = 8'($random(seed)) | 8'h01;
      wr(rsrc_pkg::ADDR_WAKE_EN, {24'h0, m});
      len = 1 + ($unsigned($random(seed)) % 4);
      cidx = (k == 3) ? rsrc_pkg::CAUSE_DEBUGGER : k;
      base = n_done;
      if (k == 3) wr(rsrc_pkg::ADDR_DEBUGGER, 32'h2);
      else far.hold_src(k, len);
      wait_done(base);
      chk_reset("system", exp_len(2'h1, k == 3 ? 1 : len), 2'h1, 1'h1);
      rd_chk("wake cleared", rsrc_pkg::ADDR_WAKE_EN, 32'h0);
      rd_chk("cause", rsrc_pkg::ADDR_CAUSE, 32'h1 << cidx);
      rd_chk("debugger bit", rsrc_pkg::ADDR_DEBUGGER, 32'h0);
      wr(rsrc_pkg::ADDR_CAUSE, 32'h3F);
    end
    $display("test system done");
    wr(rsrc_pkg::ADDR_OPTION, 32'h1);
    base = n_done;
    far.hold_src(3, 1);
    wait_done(base);
    chk_reset("short", exp_len(2'h2, 1), 2'h2, 1'h1);
    rd_chk("cause", rsrc_pkg::ADDR_CAUSE, 32'h1 << rsrc_pkg::CAUSE_WDOG);
    wr(rsrc_pkg::ADDR_CAUSE, 32'h3F);
    wr(rsrc_pkg::ADDR_OPTION, 32'h0);
    base = n_done;
    i = n_irq;
    far.hold_src(3, 1);
    repeat (6) @(posedge clk_i);
    check("irq count", i + 1, n_irq);
    check("no reset", base, n_done);
    $display("test watchdog done");
    for (k = 0; k < 3; k++) begin
      m = (8'($random(seed)) | 8'h01) & 8'h7F;
      g = 8'($random(seed));
      wr(rsrc_pkg::ADDR_WAKE_EN, {24'h0, m});
      // Pins settle before Stop is entered, so entering Stop is not itself a wake edge.
      far.set_lines(1'h0, 1'h1, g);
      far.set_lines(1'h1, 1'h1, g);
      repeat (3) @(posedge clk_i);
      base = n_done;
      far.set_lines(1'h1, 1'h1, g ^ 8'h80);
      repeat (8) @(posedge clk_i);
      check("disabled pin", {31'h0, 1'h0}, {31'h0, cpu_rst});
      if (k == 0) far.set_lines(1'h1, 1'h1, g ^ 8'h81);
      else if (k == 1) far.set_lines(1'h1, 1'h0, g ^ 8'h80);
      else far.hold_src(3, 1);
      repeat (4) @(posedge clk_i);
      far.set_lines(1'h0, 1'h1, g ^ 8'h80);
      wait_done(base);
      chk_reset("stop recovery", exp_len(2'h3, 1), 2'h3, 1'h0);
      rd_chk("wake kept", rsrc_pkg::ADDR_WAKE_EN, {24'h0, m});
      rd_chk("option kept", rsrc_pkg::ADDR_OPTION, 32'h0);
      rd_chk("cause", rsrc_pkg::ADDR_CAUSE, 32'h1 << rsrc_pkg::CAUSE_SMR);
      wr(rsrc_pkg::ADDR_CAUSE, 32'h3F);
    end
    $display("test stop recovery done");
    close_out();
  end
endmodule

`default_nettype wire
